//--- hw/asr_regs.svh
`ifndef ASR_REGS_SVH
`define ASR_REGS_SVH

// Register addresses (byte offsets inside the bank)
`define ASR_ADDR_STATUS 8'h00
`define ASR_ADDR_X_HIGH 8'h01
`define ASR_ADDR_X_LOW 8'h02
`define ASR_ADDR_Y_HIGH 8'h03
`define ASR_ADDR_Y_LOW 8'h04
`define ASR_ADDR_Z_HIGH 8'h05
`define ASR_ADDR_Z_LOW 8'h06
`define ASR_ADDR_LAST 8'h06
`define ASR_PTR_STEP 8'h01

// Bus slave address, 7 bits
`define ASR_I2C_ADDR 7'h55

// Ready-flag register layout
`define ASR_FLAG_ALL 3
`define ASR_FLAGS_RST 4'h0
`define ASR_STATUS_PAD 4'h0

// Sample packing
`define ASR_SAMPLE_W 14
`define ASR_HI_MSB 13
`define ASR_HI_LSB 6
`define ASR_LO_MSB 5
`define ASR_LO_PAD 2'h0
`define ASR_SAMPLE_RST 14'h0000
`define ASR_BYTE_ZERO 8'h00
`define ASR_AXES 3

// Scaling of one count, and full scale, in milli-g
`define ASR_MG_PER_COUNT 1
`define ASR_FULL_SCALE_MG 8000

`endif

//--- hw/asr_pkg.sv
package asr_pkg;
	// Kind of request carried from the link side to the core side
	typedef enum logic [1:0] {
		ASR_REQ_PTR,
		ASR_REQ_RD,
		ASR_REQ_STOP
	} asr_req_t;

	// Link-side handshake state
	typedef enum logic {
		ASR_LK_IDLE,
		ASR_LK_WAIT
	} asr_lk_state_t;

	typedef logic [1:0] asr_axis_t;
endpackage

//--- hw/asr_sample_bank.sv
`timescale 1ns/100ps
`default_nettype none
`include "asr_regs.svh"

module asr_sample_bank
	import asr_pkg::*;
#(
	parameter int SAMPLE_W = `ASR_SAMPLE_W
) (
	input wire logic core_clk_in, // Core clock, 20 MHz
	input wire logic rst_n_in, // Core reset, sync, active low
	input wire logic en_in, // Enable pin, asynchronous
	input wire logic x_new_in, // New X sample pulse
	input wire logic y_new_in, // New Y sample pulse
	input wire logic z_new_in, // New Z sample pulse
	input wire logic [SAMPLE_W-1:0] x_sample_value_in, // X sample
	input wire logic [SAMPLE_W-1:0] y_sample_value_in, // Y sample
	input wire logic [SAMPLE_W-1:0] z_sample_value_in, // Z sample
	input wire logic link_clk_in, // Link clock from bus engine
	input wire logic link_rst_n_in, // Link reset, sync, active low
	input wire logic lk_sel_in, // Address byte after start
	input wire logic lk_ptr_wr_in, // Register address byte written
	input wire logic lk_rd_in, // Master asks for next read byte
	input wire logic lk_stop_in, // Stop condition seen
	input wire logic [7:0] lk_byte_in, // Byte for select or pointer
	output logic lk_sel_ack_out, // Address byte matches this slave
	output logic [7:0] lk_rd_data_out, // Read byte
	output logic lk_rd_valid_out, // Read byte valid, one cycle
	output logic lk_busy_out // Request in flight, new ones ignored
);

	// ************************************************************
	// Elaboration checks
	// ************************************************************
	// Packing into a high and a low byte only works at 14 bits
	if (SAMPLE_W != `ASR_SAMPLE_W) begin : g_bad_width
		$error("asr_sample_bank: SAMPLE_W must be 14");
	end

	// ************************************************************
	// Link domain: request capture and answer return
	// ************************************************************
	asr_lk_state_t lk_state;
	asr_req_t lk_req_kind;
	logic [7:0] lk_req_byte;
	logic lk_req_tgl;
	logic [2:0] lk_ack_sync;
	logic lk_ack_seen;
	logic lk_ack_evt;
	logic lk_any_req;
	asr_req_t next_kind;

	// Core-side answer, stable while the link waits
	logic [7:0] rsp_data;
	logic ack_tgl;

	// Stop outranks a pointer write, which outranks a read
	always_comb begin
		lk_any_req = lk_stop_in | lk_ptr_wr_in | lk_rd_in;
		if (lk_stop_in) begin
			next_kind = ASR_REQ_STOP;
		end else if (lk_ptr_wr_in) begin
			next_kind = ASR_REQ_PTR;
		end else begin
			next_kind = ASR_REQ_RD;
		end
	end

	// Ack toggle enters through three stages; count it once 2nd and 3rd agree
	always_ff @(posedge link_clk_in) begin
		if (!link_rst_n_in) begin
			lk_ack_sync <= 3'h0;
			lk_ack_seen <= 1'b0;
		end else begin
			lk_ack_sync <= {lk_ack_sync[1:0], ack_tgl};
			if (lk_ack_evt) begin
				lk_ack_seen <= lk_ack_sync[2];
			end
		end
	end
	assign lk_ack_evt = (lk_ack_sync[1] == lk_ack_sync[2]) &&
		(lk_ack_sync[2] != lk_ack_seen);

	// One request in flight; others are dropped, busy shows why
	always_ff @(posedge link_clk_in) begin
		if (!link_rst_n_in) begin
			lk_state <= ASR_LK_IDLE;
			lk_req_kind <= ASR_REQ_STOP;
			lk_req_byte <= `ASR_BYTE_ZERO;
			lk_req_tgl <= 1'b0;
			lk_busy_out <= 1'b0;
			lk_rd_valid_out <= 1'b0;
			lk_rd_data_out <= `ASR_BYTE_ZERO;
		end else begin
			lk_rd_valid_out <= 1'b0;
			case (lk_state)
				ASR_LK_IDLE: begin
					if (lk_any_req) begin
						lk_req_kind <= next_kind;
						lk_req_byte <= lk_byte_in;
						lk_req_tgl <= ~lk_req_tgl;
						lk_busy_out <= 1'b1;
						lk_state <= ASR_LK_WAIT;
					end
				end
				ASR_LK_WAIT: begin
					if (lk_ack_evt) begin
						if (lk_req_kind == ASR_REQ_RD) begin
							lk_rd_data_out <= rsp_data;
							lk_rd_valid_out <= 1'b1;
						end
						lk_busy_out <= 1'b0;
						lk_state <= ASR_LK_IDLE;
					end
				end
				default: begin
					lk_state <= ASR_LK_IDLE;
					lk_busy_out <= 1'b0;
				end
			endcase
		end
	end

	// Address match answered locally; the core never sees select bytes
	always_ff @(posedge link_clk_in) begin
		if (!link_rst_n_in) begin
			lk_sel_ack_out <= 1'b0;
		end else if (lk_sel_in) begin
			lk_sel_ack_out <= (lk_byte_in[7:1] == `ASR_I2C_ADDR);
		end
	end

	// ************************************************************
	// Core domain: synchronisers
	// ************************************************************
	logic [2:0] en_sync;
	logic en_level;
	logic [2:0] req_sync;
	logic req_seen;
	logic req_evt;

	// Enable pin and request toggle, three stages each
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			en_sync <= 3'h0;
			en_level <= 1'b0;
			req_sync <= 3'h0;
			req_seen <= 1'b0;
		end else begin
			en_sync <= {en_sync[1:0], en_in};
			req_sync <= {req_sync[1:0], lk_req_tgl};
			if (en_sync[1] == en_sync[2]) begin
				en_level <= en_sync[2];
			end
			if (req_evt) begin
				req_seen <= req_sync[2];
			end
		end
	end
	assign req_evt = (req_sync[1] == req_sync[2]) &&
		(req_sync[2] != req_seen);

	// ************************************************************
	// Core domain: samples and ready flags
	// ************************************************************
	logic [SAMPLE_W-1:0] smp [`ASR_AXES];
	logic [`ASR_AXES-1:0] new_ev;
	logic [`ASR_AXES-1:0] axis_ready;
	logic [`ASR_AXES-1:0] new_seen;
	logic [`ASR_AXES-1:0] hi_read;
	logic [`ASR_AXES-1:0] rd_hi;
	logic all_ready;
	logic all_set;
	logic all_clr;
	logic [7:0] ptr;
	logic is_rd;
	logic is_hi;
	logic is_lo;
	asr_axis_t hi_axis;
	asr_axis_t lo_axis;
	logic [SAMPLE_W-1:0] in_smp [`ASR_AXES];

	assign new_ev = {z_new_in, y_new_in, x_new_in} &
		{`ASR_AXES{en_level}};
	assign in_smp[0] = x_sample_value_in;
	assign in_smp[1] = y_sample_value_in;
	assign in_smp[2] = z_sample_value_in;
	assign is_rd = req_evt && en_level && (lk_req_kind == ASR_REQ_RD);

	// Per-axis storage and flag; a new sample beats a clear in one cycle
	for (genvar a = 0; a < `ASR_AXES; a++) begin : g_axis
		assign rd_hi[a] = is_rd && is_hi && (hi_axis == asr_axis_t'(a));
		always_ff @(posedge core_clk_in) begin
			if (!rst_n_in || !en_level) begin
				smp[a] <= `ASR_SAMPLE_RST;
				axis_ready[a] <= 1'b0;
			end else begin
				if (new_ev[a]) begin
					smp[a] <= in_smp[a];
					axis_ready[a] <= 1'b1;
				end else if (rd_hi[a]) begin
					axis_ready[a] <= 1'b0;
				end
			end
		end
	end

	assign all_set = &(new_seen | new_ev);
	assign all_clr = &(hi_read | rd_hi);

	// All-axes flag needs a full fresh set, and a full set of high reads
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in || !en_level) begin
			all_ready <= 1'b0;
			new_seen <= '0;
			hi_read <= '0;
		end else begin
			new_seen <= all_set ? '0 : (new_seen | new_ev);
			hi_read <= (all_set || all_clr) ? '0 : (hi_read | rd_hi);
			if (all_set) begin
				all_ready <= 1'b1;
			end else if (all_clr) begin
				all_ready <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Core domain: pointer, read mux and low-byte holding latch
	// ************************************************************
	logic [7:0] hold_low;
	logic hold_ok;
	asr_axis_t hold_axis;
	logic [7:0] rd_byte;
	logic [7:0] ptr_next;

	// Address class of the current pointer
	always_comb begin
		is_hi = (ptr == `ASR_ADDR_X_HIGH) || (ptr == `ASR_ADDR_Y_HIGH) ||
			(ptr == `ASR_ADDR_Z_HIGH);
		is_lo = (ptr == `ASR_ADDR_X_LOW) || (ptr == `ASR_ADDR_Y_LOW) ||
			(ptr == `ASR_ADDR_Z_LOW);
		hi_axis = asr_axis_t'(ptr[2:1]);
		lo_axis = asr_axis_t'(ptr[2:1] - 2'h1);
		if (ptr == `ASR_ADDR_LAST) begin
			ptr_next = `ASR_ADDR_STATUS;
		end else begin
			ptr_next = ptr + `ASR_PTR_STEP;
		end
	end

	// Byte returned for the pointer
	always_comb begin
		rd_byte = `ASR_BYTE_ZERO;
		if (ptr == `ASR_ADDR_STATUS) begin
			rd_byte = {`ASR_STATUS_PAD, all_ready, axis_ready};
		end else if (is_hi) begin
			rd_byte = smp[hi_axis][`ASR_HI_MSB:`ASR_HI_LSB];
		end else if (is_lo && hold_ok && hold_axis == lo_axis) begin
			rd_byte = hold_low;
		end else begin
			rd_byte = `ASR_BYTE_ZERO;
		end
	end

	// Serve each request; pointer steps only on reads, a pointer write loads it, a stop resets it
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in || !en_level) begin
			ptr <= `ASR_ADDR_STATUS;
			hold_low <= `ASR_BYTE_ZERO;
			hold_ok <= 1'b0;
			hold_axis <= '0;
		end else if (req_evt) begin
			case (lk_req_kind)
				ASR_REQ_PTR: begin
					ptr <= lk_req_byte;
					hold_ok <= 1'b0;
				end
				ASR_REQ_STOP: begin
					ptr <= `ASR_ADDR_STATUS;
					hold_ok <= 1'b0;
				end
				ASR_REQ_RD: begin
					ptr <= ptr_next;
					hold_ok <= is_hi;
					if (is_hi) begin
						hold_low <= {smp[hi_axis][`ASR_LO_MSB:0],
							`ASR_LO_PAD};
						hold_axis <= hi_axis;
					end
				end
				default: begin
					hold_ok <= 1'b0;
				end
			endcase
		end
	end

	// Answer and ack; a disabled bank answers zero so no stale data leaks
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			rsp_data <= `ASR_BYTE_ZERO;
			ack_tgl <= 1'b0;
		end else if (req_evt) begin
			rsp_data <= en_level ? rd_byte : `ASR_BYTE_ZERO;
			ack_tgl <= ~ack_tgl;
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	a_disable_clears: assert property (@(posedge core_clk_in)
		disable iff (!rst_n_in)
		!en_level |=> (axis_ready == '0) && !all_ready &&
			(ptr == `ASR_ADDR_STATUS))
		else $error("flags or pointer not cleared while disabled");
	a_ptr_wrap: assert property (@(posedge core_clk_in)
		disable iff (!rst_n_in)
		is_rd && (ptr == `ASR_ADDR_LAST) |=> (ptr == `ASR_ADDR_STATUS))
		else $error("pointer did not wrap from last register");
	a_ptr_step: assert property (@(posedge core_clk_in)
		disable iff (!rst_n_in)
		is_rd && (ptr < `ASR_ADDR_LAST) |=>
			(ptr == $past(ptr) + `ASR_PTR_STEP))
		else $error("pointer did not advance by one");
	a_stop_ptr: assert property (@(posedge core_clk_in)
		disable iff (!rst_n_in)
		req_evt && (lk_req_kind == ASR_REQ_STOP) |=>
			(ptr == `ASR_ADDR_STATUS))
		else $error("stop did not discard pointer");
	a_status_pad: assert property (@(posedge core_clk_in)
		disable iff (!rst_n_in)
		is_rd && (ptr == `ASR_ADDR_STATUS) |=>
			(rsp_data[7:4] == `ASR_STATUS_PAD) &&
			(rsp_data[`ASR_FLAG_ALL] == $past(all_ready)))
		else $error("ready byte layout wrong");
	a_axis_set: assert property (@(posedge core_clk_in)
		disable iff (!rst_n_in)
		en_level && x_new_in |=> axis_ready[0])
		else $error("X flag not set on new sample");
	a_axis_clear: assert property (@(posedge core_clk_in)
		disable iff (!rst_n_in)
		rd_hi[1] && !y_new_in |=> !axis_ready[1])
		else $error("Y flag not cleared by high read");
	a_all_fall: assert property (@(posedge core_clk_in)
		disable iff (!rst_n_in)
		$fell(all_ready) && $past(en_level) |-> $past(all_clr))
		else $error("all-axes flag fell without all high reads");
	a_low_pack: assert property (@(posedge core_clk_in)
		disable iff (!rst_n_in)
		is_rd && is_lo |=> (rsp_data[1:0] == `ASR_LO_PAD))
		else $error("low byte bits 1-0 not zero");
	a_low_coherent: assert property (@(posedge core_clk_in)
		disable iff (!rst_n_in)
		is_rd && is_lo && hold_ok && (hold_axis == lo_axis) |=>
			(rsp_data == $past(hold_low)))
		else $error("low byte not from latched sample");
	a_link_pulse: assert property (@(posedge link_clk_in)
		disable iff (!link_rst_n_in)
		lk_rd_valid_out |-> !lk_busy_out && $past(lk_busy_out) ##1
			!lk_rd_valid_out)
		else $error("read valid not a single pulse at busy end");

	c_wrap: cover property (@(posedge core_clk_in) disable iff (!rst_n_in)
		is_rd && (ptr == `ASR_ADDR_LAST));
	c_all_ready: cover property (@(posedge core_clk_in)
		disable iff (!rst_n_in) $rose(all_ready));
	c_low_read: cover property (@(posedge core_clk_in)
		disable iff (!rst_n_in) is_rd && is_lo && hold_ok);

endmodule

`default_nettype wire

//--- verif/asr_link_master.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// Bus engine stand-in on the link side
// ****************************************
module asr_link_master (
	input wire logic link_clk_in, // Link clock
	input wire logic busy_in, // Request in flight
	input wire logic rd_valid_in, // Read byte strobe
	input wire logic [7:0] rd_data_in, // Read byte
	output logic lk_sel_out, // Address byte pulse
	output logic lk_ptr_wr_out, // Register address pulse
	output logic lk_rd_out, // Next byte pulse
	output logic lk_stop_out, // Stop pulse
	output logic [7:0] lk_byte_out // Byte with the pulses
);
	initial begin
		{lk_sel_out, lk_ptr_wr_out, lk_rd_out, lk_stop_out} = 4'h0;
		lk_byte_out = 8'hA5;
	end

	// One request: k = {sel, ptr, rd, stop}; gap idles first (slow master)
	// Callers order ptr, then rd, then stop sel byte 0x55+R/W
	task automatic req(input logic [3:0] k, input logic [7:0] b,
			input int gap, output logic [7:0] d, output logic ok);
		int n;
		// Unknown until a read strobe lands, so a missing answer fails
		d = 8'hXX;
		ok = 1'b1;
		repeat (gap) @(posedge link_clk_in);
		@(posedge link_clk_in);
		{lk_sel_out, lk_ptr_wr_out, lk_rd_out, lk_stop_out} <= k;
		lk_byte_out <= b;
		@(posedge link_clk_in);
		{lk_sel_out, lk_ptr_wr_out, lk_rd_out, lk_stop_out} <= 4'h0;
		// Released byte must not look like the old value
		lk_byte_out <= ~b;
		#1;
		if (k == 4'h8) begin
			@(posedge link_clk_in);
			#1;
		end else begin
			// Wait for the busy pulse, then for its end, bounded
			n = 0;
			while (busy_in !== 1'b1 && n < 4) begin
				@(posedge link_clk_in);
				#1;
				n++;
			end
			// A dropped request never raises busy; that is a failure
			ok = (busy_in === 1'b1);
			n = 0;
			while (busy_in !== 1'b0 && n < 40) begin
				@(posedge link_clk_in);
				#1;
				if (rd_valid_in === 1'b1)
					d = rd_data_in;
				n++;
			end
			ok = ok && (n < 40);
		end
	endtask
endmodule

`default_nettype wire

//--- verif/accel_sample_register_bank_tb.sv
`timescale 1ns/100ps
`default_nettype none

module accel_sample_register_bank_tb;
	import asr_pkg::*;
	logic core_clk_in = 1'b0;
	logic link_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic link_rst_n_in = 1'b0;
	logic en_in = 1'b0;
	logic [2:0] new_s = 3'h0;
	logic [13:0] xs = 14'h0000, ys = 14'h0000, zs = 14'h0000;
	wire logic sel, ptr_wr, rd, stp, ack, rdv, busy;
	wire logic [7:0] byt, rdd;
	int errors = 0;
	int checks_done = 0;
	int cycles = 0;

	// ****************************************
	// Clocks: link clock unrelated in phase
	// ****************************************
	always #25 core_clk_in = ~core_clk_in;
	initial begin
		#3.3;
		forever #7.5 link_clk_in = ~link_clk_in;
	end

	asr_sample_bank DUT (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
		.en_in(en_in), .x_new_in(new_s[0]), .y_new_in(new_s[1]),
		.z_new_in(new_s[2]), .x_sample_value_in(xs),
		.y_sample_value_in(ys), .z_sample_value_in(zs),
		.link_clk_in(link_clk_in), .link_rst_n_in(link_rst_n_in),
		.lk_sel_in(sel), .lk_ptr_wr_in(ptr_wr), .lk_rd_in(rd),
		.lk_stop_in(stp), .lk_byte_in(byt), .lk_sel_ack_out(ack),
		.lk_rd_data_out(rdd), .lk_rd_valid_out(rdv), .lk_busy_out(busy));

	asr_link_master PM (.link_clk_in(link_clk_in), .busy_in(busy),
		.rd_valid_in(rdv), .rd_data_in(rdd), .lk_sel_out(sel),
		.lk_ptr_wr_out(ptr_wr), .lk_rd_out(rd), .lk_stop_out(stp),
		.lk_byte_out(byt));

	// ****************************************
	// Helpers
	// ****************************************
	task automatic results();
		if (errors == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic logic [7:0] hi(input logic [13:0] s);
		return s[13:6];
	endfunction

	function automatic logic [7:0] lo(input logic [13:0] s);
		return {s[5:0], 2'h0};
	endfunction

	task automatic lk(input logic [3:0] k, input logic [7:0] b,
			output logic [7:0] d);
		logic ok;
		PM.req(k, b, 1, d, ok);
		if (ok !== 1'b1) begin
			errors++;
			$display("Error %0t: request not answered", $time);
		end
	endtask

	task automatic ptr(input logic [7:0] a);
		logic [7:0] d;
		lk(4'h4, a, d);
	endtask

	task automatic stop();
		logic [7:0] d;
		lk(4'h1, 8'h00, d);
	endtask

	task automatic rd_chk(input logic [7:0] exp);
		logic [7:0] d;
		lk(4'h2, 8'h00, d);
		chk(d, exp);
	endtask

	// New-sample pulses, one core cycle, m = {z, y, x}
	task automatic load(input logic [2:0] m, input logic [13:0] x, y, z);
		@(posedge core_clk_in);
		new_s <= m;
		xs <= x;
		ys <= y;
		zs <= z;
		@(posedge core_clk_in);
		new_s <= 3'h0;
		repeat (2) @(posedge core_clk_in);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_burst();
		load(3'h7, 14'h1FFF, 14'h2000, 14'h3ABC);
		ptr(8'h00);
		rd_chk(8'h0F);
		rd_chk(hi(14'h1FFF));
		rd_chk(lo(14'h1FFF));
		rd_chk(hi(14'h2000));
		rd_chk(lo(14'h2000));
		rd_chk(hi(14'h3ABC));
		rd_chk(lo(14'h3ABC));
		rd_chk(8'h00);
		stop();
	endtask

	task automatic t_flags();
		load(3'h1, 14'h0155, 14'h2000, 14'h3ABC);
		ptr(8'h00);
		rd_chk(8'h01);
		stop();
		load(3'h6, 14'h0155, 14'h0F0F, 14'h0042);
		ptr(8'h00);
		rd_chk(8'h0F);
		stop();
		ptr(8'h01);
		rd_chk(hi(14'h0155));
		stop();
		ptr(8'h03);
		rd_chk(hi(14'h0F0F));
		stop();
		ptr(8'h00);
		rd_chk(8'h0C);
		stop();
		ptr(8'h05);
		rd_chk(hi(14'h0042));
		stop();
		ptr(8'h00);
		rd_chk(8'h00);
		stop();
	endtask

	task automatic t_pair();
		load(3'h7, 14'h2A5B, 14'h0F0F, 14'h0042);
		ptr(8'h01);
		rd_chk(hi(14'h2A5B));
		load(3'h1, 14'h15A4, 14'h0F0F, 14'h0042);
		rd_chk(lo(14'h2A5B));
		stop();
		ptr(8'h02);
		rd_chk(8'h00);
		stop();
		ptr(8'h03);
		rd_chk(hi(14'h0F0F));
		stop();
		rd_chk(8'h0D);
		stop();
	endtask

	task automatic t_misc();
		logic [7:0] d;
		ptr(8'h07);
		rd_chk(8'h00);
		rd_chk(8'h00);
		stop();
		lk(4'h8, 8'hAB, d);
		chk({7'h00, ack}, 8'h01);
		lk(4'h8, 8'h57, d);
		chk({7'h00, ack}, 8'h00);
	endtask

	task automatic t_enable();
		repeat (20) @(posedge core_clk_in);
		ptr(8'h01);
		rd_chk(hi(14'h15A4));
		stop();
		@(posedge core_clk_in);
		en_in <= 1'b0;
		repeat (8) @(posedge core_clk_in);
		ptr(8'h01);
		rd_chk(8'h00);
		stop();
		@(posedge core_clk_in);
		en_in <= 1'b1;
		repeat (8) @(posedge core_clk_in);
		ptr(8'h00);
		rd_chk(8'h00);
		rd_chk(8'h00);
		stop();
	endtask

	// ****************************************
	// Sequence and watchdog
	// ****************************************
	initial begin
		repeat (6) @(posedge link_clk_in);
		link_rst_n_in <= 1'b1;
	end

	always @(posedge core_clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			errors++;
			results();
		end
	end

	initial begin
		repeat (4) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		en_in <= 1'b1;
		repeat (8) @(posedge core_clk_in);
		ptr(8'h00);
		rd_chk(8'h00);
		stop();
		t_burst();
		t_flags();
		t_pair();
		t_misc();
		t_enable();
		results();
	end
endmodule

`default_nettype wire
